// [ramecc_map.svh]
`ifndef RAMECC_MAP_SVH
`define RAMECC_MAP_SVH

`define RAMECC_CTRL_OFS      4'h0
`define RAMECC_STAT_OFS      4'h4
`define RAMECC_MASK_OFS      4'h8
`define RAMECC_INJ_OFS       4'hc

`define RAMECC_CTRL_ECC_BIT  0
`define RAMECC_CTRL_PIPE_BIT 1
`define RAMECC_CTRL_MODE_LSB 2
`define RAMECC_CTRL_INJ_BIT  4

`define RAMECC_STAT_COR_BIT  0
`define RAMECC_STAT_UNC_BIT  1

`define RAMECC_CTRL_RST      32'h0000_0000
`define RAMECC_MASK_RST      2'h0
`define RAMECC_INJ_RST       32'h0000_0000

`define RAMECC_DW            32
`define RAMECC_CW            40
`define RAMECC_HAM_TOP       38
`define RAMECC_CHK_N         6

`endif

// [ramecc_pkg.sv]
package ramecc_pkg;

	typedef enum logic [1:0] {
		RAMECC_MODE_TDP  = 2'b00,
		RAMECC_MODE_SDP  = 2'b01,
		RAMECC_MODE_PACK = 2'b10
	} ramecc_mode_t;

	typedef enum logic [1:0] {
		RAMECC_ST_OK    = 2'b00,
		RAMECC_ST_ILL   = 2'b01,
		RAMECC_ST_FIXED = 2'b10,
		RAMECC_ST_BAD   = 2'b11
	} ramecc_stat_t;

endpackage

// [ramecc_top.sv]
// How it works
// - packed mode: port number forced into address MSB picks logical memory
// - address hold keeps previous registered address
// - each port has its own hold
// - hold low means address loads normally
// - clear acts on output stages and blocks new status events
// - clear lasts until next output clock edge
// - outputs stay cleared while clear asserted
// - fix single, adjacent double only at 15-16 or 31-32; triple caught only if syndrome above 38
// - four or more errors may pass
// - ecc only in 32-bit simple dual-port
// - optional pipe before decoder, one cycle
// - error and uncorrectable flags beside data
// - 11 uncorrectable, raw data shown
// - output clock drives output regs, clear
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`include "ramecc_map.svh"

module ramecc_top
	import ramecc_pkg::*;
#(
	parameter int DEPTH = 512,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic                   i_sys_clk,
	input  wire logic                   i_rst,
	input  wire logic [AW-1:0]          i_a_addr,
	input  wire logic [`RAMECC_DW-1:0]  i_a_wdata,
	input  wire logic                   i_a_we,
	input  wire logic                   i_a_addr_stall,
	input  wire logic [AW-1:0]          i_b_addr,
	input  wire logic [`RAMECC_DW-1:0]  i_b_wdata,
	input  wire logic                   i_b_we,
	input  wire logic                   i_b_addr_stall,
	input  wire logic                   i_out_clr,
	output logic      [`RAMECC_DW-1:0]  o_a_rd_data,
	output logic      [1:0]             o_a_ecc_status,
	output logic      [`RAMECC_DW-1:0]  o_b_rd_data,
	output logic      [1:0]             o_b_ecc_status,
	input  wire logic [3:0]             i_reg_addr,
	input  wire logic [31:0]            i_reg_wdata,
	input  wire logic                   i_reg_wr,
	input  wire logic                   i_reg_rd,
	output logic      [31:0]            o_reg_rdata,
	output logic                        o_irq
);

	localparam int CW  = `RAMECC_CW;
	localparam int DW  = `RAMECC_DW;
	localparam int HT  = `RAMECC_HAM_TOP;
	localparam int CHK = `RAMECC_CHK_N;
	logic [1:0][AW-1:0] in_addr;
	logic [1:0][DW-1:0] in_wdata;
	logic [1:0]         in_we;
	logic [1:0]         in_stall;
	logic [1:0][AW-1:0] addr_q;
	logic [1:0]         we_q;
	logic [1:0][DW-1:0] wd_q;
	logic [1:0][AW-1:0] phys;
	logic [1:0]         we_eff;
	logic [1:0][CW-1:0] wcode;
	logic [1:0][CW-1:0] raw_q;
	logic [1:0][CW-1:0] pipe_q;
	logic [1:0][CW-1:0] dec_in;
	logic [1:0][DW-1:0] dec_data;
	logic [1:0][1:0]    dec_st;
	logic [1:0][DW-1:0] out_data_q;
	logic [1:0][1:0]    out_st_q;
	logic [CW-1:0]      mem [DEPTH];
	logic [31:0]        ctrl_q;
	logic [1:0]         stat_q;
	logic [1:0]         mask_q;
	logic [31:0]        inj_q;
	logic [1:0]         stat_ev;
	logic [1:0]         stat_w1c;
	logic [31:0]        rdata_q;
	ramecc_mode_t       mode;
	logic               ecc_on;
	logic               pipe_en;
	assign in_addr  = {i_b_addr, i_a_addr};
	assign in_wdata = {i_b_wdata, i_a_wdata};
	assign in_we    = {i_b_we, i_a_we};
	assign in_stall = {i_b_addr_stall, i_a_addr_stall};
	assign mode    = ramecc_mode_t'(ctrl_q[`RAMECC_CTRL_MODE_LSB +: 2]);
	assign ecc_on  = ctrl_q[`RAMECC_CTRL_ECC_BIT] && (mode == RAMECC_MODE_SDP);
	assign pipe_en = ctrl_q[`RAMECC_CTRL_PIPE_BIT];

	function automatic logic [CW-1:0] ecc_enc(input logic [DW-1:0] d);
		logic [CW-1:0] c;
		int            k;
		c = '0;
		k = 0;
		for (int p = 1; p <= HT; p++) begin
			if ((p & (p - 1)) != 0) begin
				c[p] = d[k];
				k++;
			end
		end
		for (int i = 0; i < CHK; i++) begin
			for (int p = 1; p <= HT; p++) begin
				if (p[i] && (p != (1 << i))) begin
					c[1 << i] = c[1 << i] ^ c[p];
				end
			end
		end
		c[0] = ^c[HT:1];
		return c;
	endfunction

	function automatic logic [DW-1:0] ecc_data(input logic [CW-1:0] c);
		logic [DW-1:0] d;
		int            k;
		d = '0;
		k = 0;
		for (int p = 1; p <= HT; p++) begin
			if ((p & (p - 1)) != 0) begin
				d[k] = c[p];
				k++;
			end
		end
		return d;
	endfunction
	function automatic logic [CHK-1:0] ecc_syn(input logic [CW-1:0] c);
		logic [CHK-1:0] s;
		s = '0;
		for (int i = 0; i < CHK; i++) begin
			for (int p = 1; p <= HT; p++) begin
				if (p[i]) begin
					s[i] = s[i] ^ c[p];
				end
			end
		end
		return s;
	endfunction

	// input registers: not touched by the output clear
	always_ff @(posedge i_sys_clk) begin
		for (int n = 0; n < 2; n++) begin
			if (i_rst) begin
				addr_q[n] <= '0;
				we_q[n]   <= 1'b0;
				wd_q[n]   <= '0;
			end else begin
				if (!in_stall[n]) begin
					addr_q[n] <= in_addr[n];
				end
				we_q[n] <= in_we[n];
				wd_q[n] <= in_wdata[n];
			end
		end
	end

	always_comb begin
		for (int n = 0; n < 2; n++) begin
			// upper bit forced to port number; each half holds one memory
			if (mode == RAMECC_MODE_PACK) begin
				phys[n] = {1'(n), addr_q[n][AW-2:0]};
			end else begin
				phys[n] = addr_q[n];
			end
			we_eff[n] = we_q[n] && !((mode == RAMECC_MODE_SDP) && (n == 1));
			if (ecc_on) begin
				wcode[n] = ecc_enc(wd_q[n]);
				if (ctrl_q[`RAMECC_CTRL_INJ_BIT]) begin
					wcode[n][31:0] = wcode[n][31:0] ^ inj_q;
				end
			end else begin
				wcode[n] = {{(CW - DW){1'b0}}, wd_q[n]};
			end
		end
	end

	// array: no reset, port b wins a same-address write
	always_ff @(posedge i_sys_clk) begin
		for (int n = 0; n < 2; n++) begin
			if (we_eff[n]) begin
				mem[phys[n]] <= wcode[n];
			end
		end
	end

	// output latch and pipe stage, cleared on i_out_clr
	always_ff @(posedge i_sys_clk) begin
		for (int n = 0; n < 2; n++) begin
			if (i_rst || i_out_clr) begin
				raw_q[n]  <= '0;
				pipe_q[n] <= '0;
			end else begin
				raw_q[n]  <= mem[phys[n]];
				pipe_q[n] <= raw_q[n];
			end
		end
	end

	always_comb begin
		logic [CHK-1:0] s;
		logic           par;
		logic [CW-1:0]  fixed;
		int             hits;
		int             pos;
		s     = '0;
		par   = 1'b0;
		fixed = '0;
		hits  = 0;
		pos   = 0;
		for (int n = 0; n < 2; n++) begin
			dec_in[n] = pipe_en ? pipe_q[n] : raw_q[n];
			s     = ecc_syn(dec_in[n]);
			par   = ^dec_in[n][HT:0];
			fixed = dec_in[n];
			hits  = 0;
			pos   = 0;
			if (!ecc_on) begin
				dec_st[n] = RAMECC_ST_OK;
			end else if ((s == '0) && !par) begin
				dec_st[n] = RAMECC_ST_OK;
			end else if (par) begin
				// odd weight: single error, else triple or worse
				if (s <= CHK'(HT)) begin
					fixed[s]  = ~fixed[s];
					dec_st[n] = RAMECC_ST_FIXED;
				end else begin
					dec_st[n] = RAMECC_ST_BAD;
				end
			end else begin
				// even weight: adjacent pair only if the match is unique
				for (int j = 1; j < HT; j++) begin
					if (CHK'(j ^ (j + 1)) == s) begin
						hits++;
						pos = j;
					end
				end
				if (hits == 1) begin
					fixed[pos]     = ~fixed[pos];
					fixed[pos + 1] = ~fixed[pos + 1];
					dec_st[n]      = RAMECC_ST_FIXED;
				end else begin
					dec_st[n] = RAMECC_ST_BAD;
				end
			end
			// four or more flips may alias to any outcome
			if (!ecc_on) begin
				dec_data[n] = dec_in[n][DW-1:0];
			end else if (dec_st[n] == RAMECC_ST_BAD) begin
				dec_data[n] = ecc_data(dec_in[n]);
			end else begin
				dec_data[n] = ecc_data(fixed);
			end
		end
	end

	// output registers: data and flags in one stage
	always_ff @(posedge i_sys_clk) begin
		for (int n = 0; n < 2; n++) begin
			if (i_rst || i_out_clr) begin
				out_data_q[n] <= '0;
				out_st_q[n]   <= '0;
			end else begin
				out_data_q[n] <= dec_data[n];
				out_st_q[n]   <= dec_st[n];
			end
		end
	end

	assign o_a_rd_data    = out_data_q[0];
	assign o_a_ecc_status = out_st_q[0];
	assign o_b_rd_data    = out_data_q[1];
	assign o_b_ecc_status = out_st_q[1];
	always_comb begin
		stat_ev = 2'h0;
		for (int n = 0; n < 2; n++) begin
			if (!i_out_clr && (dec_st[n] == RAMECC_ST_FIXED)) begin
				stat_ev[`RAMECC_STAT_COR_BIT] = 1'b1;
			end
			if (!i_out_clr && (dec_st[n] == RAMECC_ST_BAD)) begin
				stat_ev[`RAMECC_STAT_UNC_BIT] = 1'b1;
			end
		end
		stat_w1c = (i_reg_wr && (i_reg_addr == `RAMECC_STAT_OFS)) ? i_reg_wdata[1:0] : 2'h0;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			ctrl_q <= `RAMECC_CTRL_RST;
			mask_q <= `RAMECC_MASK_RST;
			inj_q  <= `RAMECC_INJ_RST;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				`RAMECC_CTRL_OFS: ctrl_q <= {27'h00_0000, i_reg_wdata[4:0]};
				`RAMECC_MASK_OFS: mask_q <= i_reg_wdata[1:0];
				`RAMECC_INJ_OFS:  inj_q  <= i_reg_wdata;
				default: ;
			endcase
		end
	end

	// a new event beats a same-cycle write-one-clear
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			stat_q <= 2'h0;
		end else begin
			stat_q <= (stat_q & ~stat_w1c) | stat_ev;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst || !i_reg_rd) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			case (i_reg_addr)
				`RAMECC_CTRL_OFS: rdata_q <= ctrl_q;
				`RAMECC_STAT_OFS: rdata_q <= {30'h000_0000, stat_q};
				`RAMECC_MASK_OFS: rdata_q <= {30'h000_0000, mask_q};
				`RAMECC_INJ_OFS:  rdata_q <= inj_q;
				default:          rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	assign o_reg_rdata = rdata_q;
	assign o_irq       = |(stat_q & mask_q);

	a_addr_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_a_addr_stall |=> (addr_q[0] == $past(addr_q[0])))
		else $error("address moved while held");
	a_addr_load: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!i_a_addr_stall |=> (addr_q[0] == $past(i_a_addr)))
		else $error("address not loaded without hold");
	a_port_indep: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(i_b_addr_stall && !i_a_addr_stall) |=>
		((addr_q[1] == $past(addr_q[1])) && (addr_q[0] == $past(i_a_addr))))
		else $error("port holds not independent");
	a_pack_msb: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(mode == RAMECC_MODE_PACK) |-> (!phys[0][AW-1] && phys[1][AW-1]))
		else $error("packed halves not split by msb");
	a_clr_out: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_out_clr |=> ((o_a_rd_data == '0) && (o_b_rd_data == '0) && (o_b_ecc_status == 2'h0)))
		else $error("outputs not cleared after clear");
	a_clr_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_out_clr [*3] |-> ((raw_q[1] == '0) && (o_b_rd_data == '0) && (o_a_ecc_status == 2'h0)))
		else $error("outputs left clear state during clear");
	a_ecc_gate: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(mode != RAMECC_MODE_SDP) |-> ((dec_st[0] == 2'h0) && (dec_st[1] == 2'h0)))
		else $error("ecc status outside simple dual-port");
	a_pipe_stage: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(pipe_en && $past(pipe_en) && !$past(i_out_clr)) |-> (dec_in[1] === $past(raw_q[1])))
		else $error("pipe stage not one cycle");
	a_st_legal: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(o_b_ecc_status != 2'b01) && (o_a_ecc_status != 2'b01))
		else $error("illegal ecc status");
	a_ue_raw: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(dec_st[1] == RAMECC_ST_BAD) |-> (dec_data[1] === ecc_data(dec_in[1])))
		else $error("uncorrectable word was altered");
	a_st_align: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!$past(i_out_clr) |->
		((o_b_ecc_status === $past(dec_st[1])) && (o_b_rd_data === $past(dec_data[1]))))
		else $error("flags not aligned with data");
	a_irq_level: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(stat_ev != 2'h0) |=> o_irq == |(($past(stat_ev) | stat_q) & mask_q))
		else $error("irq does not follow status");

endmodule

// [ramecc_user.sv]
`timescale 1ns/100ps
module ramecc_user #(
	parameter int AW = 9
) (
	input  wire logic          i_sys_clk,
	output logic      [AW-1:0] o_a_addr,
	output logic      [31:0]   o_a_wdata,
	output logic               o_a_we,
	output logic               o_a_addr_stall,
	output logic      [AW-1:0] o_b_addr,
	output logic      [31:0]   o_b_wdata,
	output logic               o_b_we,
	output logic               o_b_addr_stall
);
	initial begin
		{o_a_addr, o_a_wdata, o_a_we, o_a_addr_stall} = '0;
		{o_b_addr, o_b_wdata, o_b_we, o_b_addr_stall} = '0;
	end
	// one cycle on both ports, held until the next call
	task automatic drive(input logic pk, input logic [AW-1:0] a, b, input logic [31:0] da, db,
		input logic wa, wb, sa, sb);
		@(posedge i_sys_clk);
		o_a_addr <= pk ? {1'b0, a[AW-2:0]} : a;
		o_b_addr <= pk ? {1'b0, b[AW-2:0]} : b;
		// idle data lines toggle, full words only
		o_a_wdata <= wa ? da : ~o_a_wdata;
		o_b_wdata <= wb ? db : ~o_b_wdata;
		o_a_we <= wa;
		o_b_we <= wb;
		o_a_addr_stall <= sa;
		o_b_addr_stall <= sb;
	endtask
endmodule

// [testbench.sv]
`timescale 1ns/100ps
module testbench;
	import ramecc_pkg::*;
	logic        clk = 0;
	logic        rst = 1;
	logic        clr = 0;
	logic        wr  = 0;
	logic        rd  = 0;
	logic [3:0]  ra  = '0;
	logic [31:0] rwd = '0;
	logic [8:0]  aa, ba;
	logic [31:0] awd, bwd, ard, brd, rrd, d;
	logic        awe, bwe, ast, bst, irq;
	logic [1:0]  as, bs;
	logic [31:0] mem[int];
	int          n_fail = 0;
	int          n_compared = 0;
	int          cyc = 0;

	initial forever #50 clk = ~clk;

	ramecc_user i_ramecc_user (.i_sys_clk(clk), .o_a_addr(aa), .o_a_wdata(awd), .o_a_we(awe),
		.o_a_addr_stall(ast), .o_b_addr(ba), .o_b_wdata(bwd), .o_b_we(bwe),
		.o_b_addr_stall(bst));
	ramecc_top i_ramecc_top (.i_sys_clk(clk), .i_rst(rst), .i_a_addr(aa), .i_a_wdata(awd),
		.i_a_we(awe), .i_a_addr_stall(ast), .i_b_addr(ba), .i_b_wdata(bwd), .i_b_we(bwe),
		.i_b_addr_stall(bst), .i_out_clr(clr), .o_a_rd_data(ard), .o_a_ecc_status(as),
		.o_b_rd_data(brd), .o_b_ecc_status(bs), .i_reg_addr(ra), .i_reg_wdata(rwd),
		.i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rrd), .o_irq(irq));

	task automatic stop_test();
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	task automatic regw(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		ra <= a;
		rwd <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic regr(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		ra <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#10;
		chk(rrd, e);
	endtask
	task automatic rdchk(input int lat, input bit ca, input logic [31:0] ea, eb,
		input logic [1:0] es);
		repeat (lat) @(posedge clk);
		#10;
		if (ca)
			chk(ard, ea);
		if (ca)
			chk({30'h0, as}, {30'h0, es});
		chk(brd, eb);
		chk({30'h0, bs}, {30'h0, es});
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail++;
			stop_test();
		end
	end

	initial begin
		void'($urandom(20));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		regr(4'h0, 32'h0000_0000);
		regr(4'h2, 32'h0000_0000);
		for (int i = 0; i < 4; i++) begin
			d = $urandom;
			mem[i] = d;
			mem[i + 16] = ~d;
			i_ramecc_user.drive(0, 9'(i), 9'(i + 16), d, ~d, 1, 1, 0, 0);
		end
		for (int i = 0; i < 4; i++) begin
			i_ramecc_user.drive(0, 9'(i + 16), 9'(i), 0, 0, 0, 0, 0, 0);
			rdchk(3, 1, mem[i + 16], mem[i], 2'b00);
		end
		i_ramecc_user.drive(0, 9'd1, 9'd2, 0, 0, 0, 0, 0, 0);
		i_ramecc_user.drive(0, 9'd3, 9'd0, 0, 0, 0, 0, 1, 0);
		rdchk(3, 1, mem[1], mem[0], 2'b00);
		i_ramecc_user.drive(0, 9'd2, 9'd3, 0, 0, 0, 0, 0, 1);
		rdchk(3, 1, mem[2], mem[0], 2'b00);
		@(posedge clk);
		clr <= 1'b1;
		rdchk(1, 1, 0, 0, 2'b00);
		rdchk(2, 1, 0, 0, 2'b00);
		@(posedge clk);
		clr <= 1'b0;
		rdchk(1, 1, 0, 0, 2'b00);
		rdchk(1, 1, mem[2], mem[0], 2'b00);
		regw(4'h0, 32'h0000_0008);
		d = $urandom;
		i_ramecc_user.drive(1, 9'd5, 9'd5, d, ~d, 1, 1, 0, 0);
		i_ramecc_user.drive(1, 9'd5, 9'd5, 0, 0, 0, 0, 0, 0);
		rdchk(3, 1, d, ~d, 2'b00);
		regw(4'h0, 32'h0000_0005);
		for (int i = 7; i < 11; i++) begin
			if (i == 8)
				regw(4'h0, 32'h0000_0015);
			if (i == 10)
				regw(4'hc, 32'h0000_0009);
			mem[i] = $urandom;
			// one write cycle, then park both ports on a clean word
			i_ramecc_user.drive(0, 9'(i), 9'd7, mem[i], 0, 1, 0, 0, 0);
			i_ramecc_user.drive(0, 9'd7, 9'd7, 0, 0, 0, 0, 0, 0);
			if (i == 7)
				regw(4'hc, 32'h0000_0008);
		end
		regw(4'h0, 32'h0000_0005);
		regw(4'h4, 32'h0000_0003);
		i_ramecc_user.drive(0, 9'd7, 9'd7, 0, 0, 0, 0, 0, 0);
		rdchk(3, 0, 0, mem[7], 2'b00);
		i_ramecc_user.drive(0, 9'd7, 9'd8, 0, 0, 0, 0, 0, 0);
		rdchk(3, 0, 0, mem[8], 2'b10);
		i_ramecc_user.drive(0, 9'd7, 9'd7, 0, 0, 0, 0, 0, 0);
		rdchk(3, 0, 0, mem[7], 2'b00);
		regr(4'h4, 32'h0000_0001);
		regw(4'h8, 32'h0000_0001);
		#10 chk(irq, 1'b1);
		regw(4'h4, 32'h0000_0001);
		#10 chk(irq, 1'b0);
		i_ramecc_user.drive(0, 9'd7, 9'd10, 0, 0, 0, 0, 0, 0);
		rdchk(3, 0, 0, mem[10] ^ 32'h0000_0001, 2'b11);
		regw(4'h8, 32'h0000_0002);
		#10 chk(irq, 1'b1);
		i_ramecc_user.drive(0, 9'd7, 9'd9, 0, 0, 0, 0, 0, 0);
		regw(4'h0, 32'h0000_0007);
		i_ramecc_user.drive(0, 9'd7, 9'd7, 0, 0, 0, 0, 0, 0);
		rdchk(3, 0, 0, mem[9], 2'b10);
		rdchk(1, 0, 0, mem[7], 2'b00);
		stop_test();
	end
endmodule
